/* spm_pkg.sv */
// Package: register map, field layout and reset values of the shared pin I/O mux.
// Assumes a 16-bit data space bus and up to sixteen pin slots (two 8-pin ports).
// How it works
// [R1] Select bit 1 picks primary, 0 picks I/O
// [R2] In I/O mode direction 0 input, 1 output
// [R3] Input reads pin level; output drives written data
// [R4] Data and direction ignored while primary selected
// [R5] Select register bits steer per-pin multiplexers
// [R6] Select register at 7090h, resets to zero
// [R7] Port A data low byte, direction high byte
// [R8] Port B data low byte, direction high byte
// [R9] Fault input stays live in I/O mode
// [R10] All control held in 16-bit registers
// [R11] Registers reached by ordinary data-space accesses
// [R12] Pin levels synchronised before software reads them
package spm_pkg;
    localparam int REG_W = 16;
    localparam int ADDR_W = 16;
    localparam int PORT_W = 8;
    localparam int PINS = 16;
    localparam logic [ADDR_W-1:0] ADDR_SELECT = 16'h7090;
    localparam logic [ADDR_W-1:0] ADDR_PORT_A = 16'h7098;
    localparam logic [ADDR_W-1:0] ADDR_PORT_B = 16'h709A;
    localparam logic [REG_W-1:0] RST_SELECT = 16'h0000;
    localparam logic [REG_W-1:0] RST_PORT = 16'h0000;
    localparam logic [REG_W-1:0] READ_NONE = 16'h0000;
    localparam int DATA_LSB = 0;
    localparam int DIR_LSB = 8;
    localparam int FAULT_PIN = 0;
    localparam int SYNC_STAGES = 3;
endpackage : spm_pkg

/* spm_sync.sv */
// Three-stage pin synchroniser; a change is accepted once stages two and three agree.
// Assumes inputs are asynchronous to clock.
`timescale 1ns/10ps
`default_nettype none
module spm_sync #(
    parameter int WIDTH = 16
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
        end
        else
        begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge clock or negedge nrst)
            begin
                if (!nrst)
                    out_reg[i] <= 1'b0;
                else if (s2_reg[i] == s3_reg[i])
                    out_reg[i] <= s3_reg[i]; // R12
            end
        end
    endgenerate

    assign sync_out = out_reg;
endmodule : spm_sync
`default_nettype wire

/* spm_io_mux.sv */
// Shared pin I/O mux: function select, port data/direction registers and pin drive.
// Assumes a single-cycle data-space strobe bus and pins resolved outside from out/oe_n.
`timescale 1ns/10ps
`default_nettype none
module spm_io_mux (
    input wire logic clock,
    input wire logic nrst,
    input wire logic bus_sel,
    input wire logic bus_wr,
    input wire logic bus_rd,
    input wire logic [spm_pkg::ADDR_W-1:0] bus_addr,
    input wire logic [spm_pkg::REG_W-1:0] bus_wdata,
    output logic [spm_pkg::REG_W-1:0] bus_rdata,
    input wire logic [spm_pkg::PINS-1:0] periph_out,
    input wire logic [spm_pkg::PINS-1:0] periph_oe,
    output logic [spm_pkg::PINS-1:0] periph_in,
    output logic fault_shutdown_input,
    input wire logic [spm_pkg::PINS-1:0] pin_in,
    output logic [spm_pkg::PINS-1:0] pin_out,
    output logic [spm_pkg::PINS-1:0] pin_oe_n
);
    import spm_pkg::*;

    logic [REG_W-1:0] pin_function_select_reg;
    logic [REG_W-1:0] port_a_data_direction_reg;
    logic [REG_W-1:0] port_b_data_direction_reg;
    logic [REG_W-1:0] bus_rdata_reg;
    logic [PINS-1:0] pin_out_reg;
    logic [PINS-1:0] pin_oe_n_reg;
    logic [PINS-1:0] periph_in_reg;
    logic fault_reg;
    logic [PINS-1:0] pin_level;
    logic [PINS-1:0] io_data;
    logic [PINS-1:0] io_dir;
    logic [REG_W-1:0] read_next;
    logic wr_select;
    logic wr_port_a;
    logic wr_port_b;
    logic rd_strobe;

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base);
        hit = (addr == base);
    endfunction : hit

    // Data bits show the pin level for inputs and the latch for outputs
    function automatic logic [REG_W-1:0] port_view(input logic [REG_W-1:0] r, input logic [PORT_W-1:0] lvl);
        logic [PORT_W-1:0] dir;
        logic [PORT_W-1:0] dat;
        dir = r[DIR_LSB +: PORT_W];
        dat = r[DATA_LSB +: PORT_W];
        port_view = {dir, (dir & dat) | (~dir & lvl)};
    endfunction : port_view

    spm_sync #(
        .WIDTH(PINS)
    ) u_sync (
        .clock(clock),
        .nrst(nrst),
        .async_in(pin_in),
        .sync_out(pin_level)
    );

    assign io_data = {port_b_data_direction_reg[DATA_LSB +: PORT_W], port_a_data_direction_reg[DATA_LSB +: PORT_W]};
    assign io_dir = {port_b_data_direction_reg[DIR_LSB +: PORT_W], port_a_data_direction_reg[DIR_LSB +: PORT_W]};

    // Write strobes, one per mapped word
    assign wr_select = bus_sel && bus_wr && hit(bus_addr, ADDR_SELECT);
    assign wr_port_a = bus_sel && bus_wr && hit(bus_addr, ADDR_PORT_A);
    assign wr_port_b = bus_sel && bus_wr && hit(bus_addr, ADDR_PORT_B);
    assign rd_strobe = bus_sel && bus_rd;

    // Register writes, whole 16-bit words
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            pin_function_select_reg <= RST_SELECT; // R6
        else if (wr_select)
            pin_function_select_reg <= bus_wdata; // R10 R11
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            port_a_data_direction_reg <= RST_PORT;
        else if (wr_port_a)
            port_a_data_direction_reg <= bus_wdata; // R7
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            port_b_data_direction_reg <= RST_PORT;
        else if (wr_port_b)
            port_b_data_direction_reg <= bus_wdata; // R8
    end

    // Read path
    always_comb
    begin
        read_next = READ_NONE;
        if (hit(bus_addr, ADDR_SELECT))
            read_next = pin_function_select_reg;
        else if (hit(bus_addr, ADDR_PORT_A))
            read_next = port_view(port_a_data_direction_reg, pin_level[PORT_W-1:0]); // R3 R12
        else if (hit(bus_addr, ADDR_PORT_B))
            read_next = port_view(port_b_data_direction_reg, pin_level[PINS-1:PORT_W]); // R3 R12
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            bus_rdata_reg <= READ_NONE;
        else if (rd_strobe)
            bus_rdata_reg <= read_next; // R11
    end

    // Per-pin multiplexer
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            pin_out_reg <= '0;
            pin_oe_n_reg <= '1;
        end
        else
        begin
            pin_out_reg <= (pin_function_select_reg & periph_out) | (~pin_function_select_reg & io_data); // R1 R3 R4 R5
            pin_oe_n_reg <= ~((pin_function_select_reg & periph_oe) | (~pin_function_select_reg & io_dir)); // R2 R4
        end
    end

    // Peripherals always see pin levels; fault path ignores the select bit
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            periph_in_reg <= '0;
            fault_reg <= 1'b0;
        end
        else
        begin
            periph_in_reg <= pin_level;
            fault_reg <= pin_level[FAULT_PIN]; // R9
        end
    end

    assign bus_rdata = bus_rdata_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe_n = pin_oe_n_reg;
    assign periph_in = periph_in_reg;
    assign fault_shutdown_input = fault_reg;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    // Pin multiplexer checks
    a_mux_out_select: assert property ( // R1
        ##1 pin_out == $past((pin_function_select_reg & periph_out) | (~pin_function_select_reg & io_data)))
        else $error("pin output not from selected source");
    a_dir_to_enable: assert property ( // R2
        (pin_function_select_reg == '0) |=> pin_oe_n == ~$past(io_dir))
        else $error("I/O direction not reflected on output enable");
    a_dir_per_pin: assert property ( // R2
        ##1 (pin_oe_n | $past(pin_function_select_reg)) == (~$past(io_dir) | $past(pin_function_select_reg)))
        else $error("I/O direction not reflected on a pin enable");
    a_primary_ignores_io: assert property ( // R4
        ##1 ((pin_out ^ $past(periph_out)) & $past(pin_function_select_reg)) == '0
            && ((pin_oe_n ^ ~$past(periph_oe)) & $past(pin_function_select_reg)) == '0)
        else $error("port bits leaked onto primary pins");

    // Register bus checks
    a_select_write: assert property ( // R5
        bus_sel && bus_wr && bus_addr == ADDR_SELECT |=> pin_function_select_reg == $past(bus_wdata))
        else $error("select register write lost");
    a_port_a_write: assert property ( // R7
        bus_sel && bus_wr && bus_addr == ADDR_PORT_A |=> port_a_data_direction_reg == $past(bus_wdata))
        else $error("port A write lost");
    a_port_b_write: assert property ( // R8
        bus_sel && bus_wr && bus_addr == ADDR_PORT_B |=> port_b_data_direction_reg == $past(bus_wdata))
        else $error("port B write lost");
    a_input_read: assert property ( // R3
        bus_sel && bus_rd && bus_addr == ADDR_PORT_A && port_a_data_direction_reg[DIR_LSB +: PORT_W] == '0
        |=> bus_rdata[PORT_W-1:0] == $past(pin_level[PORT_W-1:0]))
        else $error("input read does not return pin level");
    a_output_read: assert property ( // R3
        bus_sel && bus_rd && bus_addr == ADDR_PORT_A
        |=> bus_rdata[DIR_LSB +: PORT_W] == $past(port_a_data_direction_reg[DIR_LSB +: PORT_W])
            && ((bus_rdata[PORT_W-1:0] ^ $past(port_a_data_direction_reg[DATA_LSB +: PORT_W]))
            & $past(port_a_data_direction_reg[DIR_LSB +: PORT_W])) == '0)
        else $error("output read does not return latched data");
    a_port_b_input: assert property ( // R3
        bus_sel && bus_rd && bus_addr == ADDR_PORT_B
        |=> ((bus_rdata[PORT_W-1:0] ^ $past(pin_level[PINS-1:PORT_W]))
            & ~$past(port_b_data_direction_reg[DIR_LSB +: PORT_W])) == '0)
        else $error("port B input read does not return pin level");
    a_rdata_hold: assert property ( // R11
        !(bus_sel && bus_rd) |=> $stable(bus_rdata))
        else $error("read data changed without a read");
    a_unmapped_write: assert property ( // R11
        bus_sel && bus_wr && bus_addr != ADDR_SELECT && bus_addr != ADDR_PORT_A && bus_addr != ADDR_PORT_B
        |=> $stable(pin_function_select_reg) && $stable(port_a_data_direction_reg)
            && $stable(port_b_data_direction_reg))
        else $error("unmapped write changed a register");
    a_unmapped_zero: assert property ( // R11
        bus_sel && bus_rd && bus_addr != ADDR_SELECT && bus_addr != ADDR_PORT_A && bus_addr != ADDR_PORT_B
        |=> bus_rdata == READ_NONE)
        else $error("unmapped read not zero");

    // Input path checks
    a_fault_live: assert property ( // R9
        ##1 fault_shutdown_input == $past(pin_level[FAULT_PIN]))
        else $error("fault input not following pin");
    a_sync_settle: assert property ( // R12
        $stable(pin_in)[*8] |-> periph_in == pin_in)
        else $error("synchronised level not settled");

    c_select_primary: cover property (bus_sel && bus_wr && bus_addr == ADDR_SELECT && bus_wdata != '0);
    c_read_port_a: cover property (bus_sel && bus_rd && bus_addr == ADDR_PORT_A);
    c_periph_drive: cover property (pin_function_select_reg[1] && !pin_oe_n[1]);
    c_io_output: cover property (!pin_function_select_reg[8] && !pin_oe_n[8]);
    c_fault_in_io: cover property (!pin_function_select_reg[FAULT_PIN] && fault_shutdown_input);
endmodule : spm_io_mux
`default_nettype wire

/* spm_pad_model.sv */
// Pad model: resolves each pin from the mux drive and the level held by the outside world.
// Assumes pin_oe_n is active low and the outside world only drives undriven pins.
`timescale 1ns/10ps
`default_nettype none
module spm_pad_model (
    input wire logic [spm_pkg::PINS-1:0] pin_out,
    input wire logic [spm_pkg::PINS-1:0] pin_oe_n,
    input wire logic [spm_pkg::PINS-1:0] ext_level,
    output logic [spm_pkg::PINS-1:0] pin_in
);
    import spm_pkg::*;
    // Driven pins read back their own drive
    assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext_level);
endmodule : spm_pad_model
`default_nettype wire

/* tb.sv */
// Testbench: register bus accesses, peripheral lines and pad levels against the mux.
// Assumes the pad model loops driven pins back onto pin_in.
`timescale 1ns/10ps
`default_nettype none
module tb;
    import spm_pkg::*;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic bus_sel = 1'b0;
    logic bus_wr = 1'b0;
    logic bus_rd = 1'b0;
    logic [ADDR_W-1:0] bus_addr = '0;
    logic [REG_W-1:0] bus_wdata = '0;
    logic [REG_W-1:0] bus_rdata;
    logic [PINS-1:0] periph_out = '0;
    logic [PINS-1:0] periph_oe = '0;
    logic [PINS-1:0] ext_level = '0;
    logic [PINS-1:0] pin_in;
    logic [PINS-1:0] pin_out;
    logic [PINS-1:0] pin_oe_n;
    logic [PINS-1:0] periph_in;
    logic fault_shutdown_input;
    logic rd_d = 1'b0;
    logic [REG_W-1:0] exp_q[$];
    logic [15:0] r;
    logic [15:0] s;
    logic [15:0] m;
    int miscompares = 0;
    int n_compared = 0;
    int seed = 32'hb962_b737;
    spm_io_mux i_spm_io_mux (.clock(clock), .nrst(nrst), .bus_sel(bus_sel), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .periph_out(periph_out), .periph_oe(periph_oe), .periph_in(periph_in),
        .fault_shutdown_input(fault_shutdown_input), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n));
    spm_pad_model i_spm_pad_model (.pin_out(pin_out), .pin_oe_n(pin_oe_n), .ext_level(ext_level),
        .pin_in(pin_in));
    always #12.5 clock = ~clock;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic check_pin(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[ERR] t=%0t pin got=%h exp=%h", $time, got, exp);
        end
    endtask : check_pin
    task automatic print_verdict;
        if (exp_q.size() != 0)
        begin
            miscompares++;
        end
        $display("compared=%0d miscompares=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
        begin
            $display("Regression OK");
        end
        else
        begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    task automatic wt(input int n);
        repeat (n) @(posedge clock);
        #2;
    endtask : wt
    // One access per call; reads note their expected word
    task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        #2;
        bus_sel = 1'b1;
        bus_wr = wr;
        bus_rd = ~wr;
        bus_addr = a;
        bus_wdata = d;
        if (!wr)
        begin
            exp_q.push_back(d);
        end
    endtask : acc
    task automatic idle;
        @(posedge clock);
        #2;
        bus_sel = 1'b0;
    endtask : idle
    // Read data lands one edge after the read is taken
    always @(posedge clock)
    begin
        if (rd_d && exp_q.size() > 0)
        begin
            check(bus_rdata, exp_q.pop_front());
        end
        rd_d <= bus_sel & bus_rd;
    end
    initial
    begin
        #(25 * 3000);
        miscompares++;
        print_verdict();
    end
    initial
    begin
        repeat (5) @(posedge clock);
        #2;
        nrst = 1'b1;
        ext_level = 16'($random(seed));
        wt(8);
        check_pin(pin_oe_n, 16'hffff);
        acc(1'b0, ADDR_SELECT, RST_SELECT);
        acc(1'b0, ADDR_PORT_A, {8'h00, ext_level[7:0]});
        acc(1'b1, ADDR_PORT_A, 16'h0101);
        r = 16'($random(seed));
        acc(1'b1, ADDR_PORT_B, {8'hff, r[7:0]});
        acc(1'b0, ADDR_PORT_B, {8'hff, r[7:0]});
        acc(1'b1, 16'h7092, 16'hffff);
        acc(1'b0, 16'h7092, READ_NONE);
        idle();
        wt(3);
        check_pin(pin_oe_n, 16'h00fe);
        check_pin(pin_out, {r[7:0], 8'h01});
        wt(8);
        check_pin({15'h0000, fault_shutdown_input}, 16'h0001);
        check_pin(periph_in, {r[7:0], ext_level[7:1], 1'b1});
        acc(1'b1, ADDR_PORT_A, 16'h0100);
        idle();
        wt(10);
        check_pin({15'h0000, fault_shutdown_input}, 16'h0000);
        repeat (4)
        begin
            s = 16'($random(seed));
            periph_out = 16'($random(seed));
            periph_oe = 16'($random(seed));
            acc(1'b1, ADDR_SELECT, s);
            acc(1'b0, ADDR_SELECT, s);
            idle();
            wt(3);
            m = s | 16'hff01;
            check_pin(pin_oe_n, (s & ~periph_oe) | (~s & 16'h00fe));
            check_pin(pin_out & m, ((s & periph_out) | (~s & {r[7:0], 8'h00})) & m);
        end
        wt(3);
        print_verdict();
    end
endmodule : tb
`default_nettype wire
